// File: fsh_ctrl.sv
// Purpose: Host controller that drives a parallel flash through its strobes.
// Assumes: APB slave for software, zero wait states, asynchronous flash pins.
// Notes:   Software issues bus cycles, unlock sequences and status polls.
//
// Behaviour
// - Host writes resume; repeats ignored.
// - Host enters ID with two unlocks, command.
// - ID reads repeat; host resets to leave.
// - Host delays toggle checks, re-reads data.
`include "fsh_map.svh"
module fsh_ctrl #(
   parameter int ERASE_WAIT_CYC = `FSH_ERASE_WAIT_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [19:0] fl_addr_o,
   output logic      [15:0] fl_dq_o,
   output logic             fl_dq_oe_o,
   input  wire logic [15:0] fl_dq_i,
   output logic             fl_ce_n_o,
   output logic             fl_we_n_o,
   output logic             fl_oe_n_o,
   input  wire logic        ready_busy_n_out_i
);
   ////////////////////////////////////////////////////////////////////////////////
   // Register file.
   fsh_pkg::fsh_op_e    op_q;
   fsh_pkg::fsh_state_e state_q;
   logic                erase_q;
   logic [19:0]         addr_q;
   logic [15:0]         wdata_q;
   logic [15:0]         rdata_q;
   logic [19:0]         unlk_a1_q;
   logic [19:0]         unlk_a2_q;
   logic [15:0]         codes_q;
   logic                fail_q;
   logic [1:0]          step_q;
   logic [7:0]          cnt_q;
   logic [23:0]         wait_q;
   logic                have_prev_q;
   logic                prev_tog_q;
   logic                limit_q;
   logic                final_q;
   logic [15:0]         dq_sync;
   logic [0:0]          rb_sync;
   wire                 busy     = (state_q != fsh_pkg::ST_IDLE);
   wire                 acc      = psel && penable;
   wire                 wr_acc   = acc && pwrite;
   wire                 sel_ctrl = (paddr == `FSH_OFS_CTRL);
   wire                 sel_addr = (paddr == `FSH_OFS_ADDR);
   wire                 sel_wdat = (paddr == `FSH_OFS_WDATA);
   wire                 sel_rdat = (paddr == `FSH_OFS_RDATA);
   wire                 sel_stat = (paddr == `FSH_OFS_STATUS);
   wire                 sel_ua1  = (paddr == `FSH_OFS_UNLK_A1);
   wire                 sel_ua2  = (paddr == `FSH_OFS_UNLK_A2);
   wire                 sel_code = (paddr == `FSH_OFS_CODES);
   wire                 mapped   = sel_ctrl | sel_addr | sel_wdat | sel_rdat | sel_stat
                                 | sel_ua1 | sel_ua2 | sel_code;
   wire [2:0]           op_wr    = pwdata[`FSH_CTRL_OP_MSB:`FSH_CTRL_OP_LSB];
   wire                 op_ok    = (op_wr >= 3'(fsh_pkg::OP_WRITE))
                                 && (op_wr <= 3'(fsh_pkg::OP_POLL));
   wire                 start    = wr_acc && sel_ctrl && !busy && op_ok;
   wire [31:0]          status   = {28'h0000000, rdata_q[`FSH_DQ_TIMER], fail_q,
                                    rb_sync[0], busy};

   assign pready  = 1'b1;
   assign pslverr = acc && (!mapped || (wr_acc && sel_ctrl && busy));
   assign prdata  = !acc ? 32'h00000000 :
                    sel_ctrl ? {28'h0000000, erase_q, 3'(op_q)} :
                    sel_addr ? {12'h000, addr_q} :
                    sel_wdat ? {16'h0000, wdata_q} :
                    sel_rdat ? {16'h0000, rdata_q} :
                    sel_stat ? status :
                    sel_ua1  ? {12'h000, unlk_a1_q} :
                    sel_ua2  ? {12'h000, unlk_a2_q} :
                    sel_code ? {16'h0000, codes_q} : 32'h00000000;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         addr_q    <= 20'h00000;
         wdata_q   <= 16'h0000;
         unlk_a1_q <= `FSH_RST_UNLK_A1;
         unlk_a2_q <= `FSH_RST_UNLK_A2;
         codes_q   <= `FSH_RST_CODES;
         erase_q   <= 1'b0;
      end
      else if (wr_acc && !busy)
      begin
         if (sel_addr)
         begin
            addr_q <= pwdata[19:0];
         end
         else if (sel_wdat)
         begin
            wdata_q <= pwdata[15:0];
         end
         else if (sel_ua1)
         begin
            unlk_a1_q <= pwdata[19:0];
         end
         else if (sel_ua2)
         begin
            unlk_a2_q <= pwdata[19:0];
         end
         else if (sel_code)
         begin
            codes_q <= pwdata[15:0];
         end
         else if (sel_ctrl)
         begin
            erase_q <= pwdata[`FSH_CTRL_ERASE];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   fsh_sync #(.W(16)) u_dq_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (fl_dq_i),
      .q_o   (dq_sync)
   );
   fsh_sync #(.W(1)) u_rb_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (ready_busy_n_out_i),
      .q_o   (rb_sync)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Cycle selection: unlock pair then command, or a single cycle.
   fsh_pkg::fsh_cyc_s cyc;
   wire               is_cmd = (op_q == fsh_pkg::OP_CMD);
   assign cyc.wr   = (op_q == fsh_pkg::OP_WRITE) || is_cmd;
   assign cyc.addr = !is_cmd ? addr_q :
                     (step_q == 2'd0) ? unlk_a1_q :
                     (step_q == 2'd1) ? unlk_a2_q : addr_q;
   assign cyc.data = !is_cmd ? wdata_q :
                     (step_q == 2'd0) ? {8'h00, codes_q[15:8]} :
                     (step_q == 2'd1) ? {8'h00, codes_q[7:0]} : wdata_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Status poll decisions after each read.
   wire tog     = rdata_q[`FSH_DQ_TOGGLE];
   wire lim     = rdata_q[`FSH_DQ_LIMIT];
   wire hold_er = erase_q && !rdata_q[`FSH_DQ_TIMER]
                  && (wait_q < 24'(ERASE_WAIT_CYC));
   wire stable  = have_prev_q && (tog == prev_tog_q);
   wire failed  = have_prev_q && !stable && limit_q;
   wire is_poll = (op_q == fsh_pkg::OP_POLL);
   wire last    = is_poll ? (final_q || failed) :
                  is_cmd ? (step_q == 2'd2) : 1'b1;

   fsh_pkg::fsh_strb_s strb;
   assign strb.ce_n  = !(state_q == fsh_pkg::ST_SETUP || state_q == fsh_pkg::ST_STRB);
   assign strb.we_n  = !(state_q == fsh_pkg::ST_STRB && cyc.wr);
   assign strb.oe_n  = !(state_q == fsh_pkg::ST_STRB && !cyc.wr);
   assign strb.dq_oe = busy && cyc.wr;
   assign fl_ce_n_o  = strb.ce_n;
   assign fl_we_n_o  = strb.we_n;
   assign fl_oe_n_o  = strb.oe_n;
   assign fl_dq_oe_o = strb.dq_oe;
   assign fl_addr_o  = cyc.addr;
   assign fl_dq_o    = cyc.data;

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q     <= fsh_pkg::ST_IDLE;
         op_q        <= fsh_pkg::OP_NONE;
         step_q      <= 2'd0;
         cnt_q       <= 8'h00;
         rdata_q     <= 16'h0000;
         fail_q      <= 1'b0;
         wait_q      <= 24'h000000;
         have_prev_q <= 1'b0;
         prev_tog_q  <= 1'b0;
         limit_q     <= 1'b0;
         final_q     <= 1'b0;
      end
      else
      begin
         if (busy && wait_q != 24'hFFFFFF)
         begin
            wait_q <= wait_q + 24'h000001;
         end
         case (state_q)
            fsh_pkg::ST_IDLE:
            begin
               if (start)
               begin
                  op_q        <= fsh_pkg::fsh_op_e'(op_wr);
                  step_q      <= 2'd0;
                  fail_q      <= 1'b0;
                  wait_q      <= 24'h000000;
                  have_prev_q <= 1'b0;
                  limit_q     <= 1'b0;
                  final_q     <= 1'b0;
                  cnt_q       <= 8'(`FSH_SETUP_CYC);
                  state_q     <= fsh_pkg::ST_SETUP;
               end
            end
            fsh_pkg::ST_SETUP:
            begin
               if (cnt_q <= 8'h01)
               begin
                  cnt_q   <= cyc.wr ? 8'(`FSH_STRB_CYC) : 8'(`FSH_STRB_CYC + `FSH_SYNC_CYC);
                  state_q <= fsh_pkg::ST_STRB;
               end
               else
               begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            fsh_pkg::ST_STRB:
            begin
               if (cnt_q <= 8'h01)
               begin
                  if (!cyc.wr)
                  begin
                     rdata_q <= dq_sync;
                  end
                  cnt_q   <= 8'(`FSH_HOLD_CYC);
                  state_q <= fsh_pkg::ST_HOLD;
               end
               else
               begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            fsh_pkg::ST_HOLD:
            begin
               if (cnt_q > 8'h01)
               begin
                  cnt_q <= cnt_q - 8'h01;
               end
               else if (last)
               begin
                  fail_q  <= is_poll && failed;
                  state_q <= fsh_pkg::ST_IDLE;
               end
               else
               begin
                  if (is_cmd)
                  begin
                     step_q <= step_q + 2'd1;
                  end
                  else if (hold_er)
                  begin
                     have_prev_q <= 1'b0;
                  end
                  else if (stable)
                  begin
                     final_q <= 1'b1;
                  end
                  else
                  begin
                     have_prev_q <= 1'b1;
                     prev_tog_q  <= tog;
                     limit_q     <= lim;
                  end
                  cnt_q   <= 8'(`FSH_SETUP_CYC);
                  state_q <= fsh_pkg::ST_SETUP;
               end
            end
            default:
            begin
               state_q <= fsh_pkg::ST_IDLE;
            end
         endcase
      end
   end
endmodule

// File: fsh_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the flash host.
// Assumes: 32-bit APB data, byte addresses, 250 MHz clock.
// Notes:   Definitions only.
`ifndef FSH_MAP_SVH
`define FSH_MAP_SVH
`define FSH_CLK_NS        4
`define FSH_OFS_CTRL      12'h000
`define FSH_OFS_ADDR      12'h004
`define FSH_OFS_WDATA     12'h008
`define FSH_OFS_RDATA     12'h00C
`define FSH_OFS_STATUS    12'h010
`define FSH_OFS_UNLK_A1   12'h014
`define FSH_OFS_UNLK_A2   12'h018
`define FSH_OFS_CODES     12'h01C
`define FSH_CTRL_OP_LSB   0
`define FSH_CTRL_OP_MSB   2
`define FSH_CTRL_ERASE    3
`define FSH_ST_BUSY       0
`define FSH_ST_READY      1
`define FSH_ST_FAIL       2
`define FSH_ST_TIMER      3
`define FSH_RST_UNLK_A1   20'h00000
`define FSH_RST_UNLK_A2   20'h00000
`define FSH_RST_CODES     16'h0000
`define FSH_DQ_POLL       7
`define FSH_DQ_TOGGLE     6
`define FSH_DQ_LIMIT      5
`define FSH_DQ_TIMER      3
`define FSH_T_SETUP_NS    20
`define FSH_T_STRB_NS     70
`define FSH_T_HOLD_NS     30
`define FSH_T_ERASE_WAIT_NS 100000
`define FSH_SYNC_CYC      3
`define FSH_SETUP_CYC     ((`FSH_T_SETUP_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_STRB_CYC      ((`FSH_T_STRB_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_HOLD_CYC      ((`FSH_T_HOLD_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_ERASE_WAIT_CYC ((`FSH_T_ERASE_WAIT_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`endif

// File: fsh_pkg.sv
// Purpose: Types shared by the flash host files.
// Assumes: Nothing beyond the map header.
// Notes:   No constants live here.
package fsh_pkg;
   typedef enum logic [2:0] {OP_NONE, OP_WRITE, OP_READ, OP_CMD, OP_POLL} fsh_op_e;
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STRB, ST_HOLD} fsh_state_e;
   typedef struct packed {
      logic        wr;
      logic [19:0] addr;
      logic [15:0] data;
   } fsh_cyc_s;
   typedef struct packed {
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
      logic        dq_oe;
   } fsh_strb_s;
endpackage

// File: fsh_sync.sv
// Purpose: Three-flop synchroniser for pin inputs, one per bit.
// Assumes: Inputs are asynchronous to clk_i.
// Notes:   The output changes only when the second and third flops agree.
module fsh_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         logic s1_q;
         logic s2_q;
         logic s3_q;
         always_ff @(posedge clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               s1_q      <= 1'b0;
               s2_q      <= 1'b0;
               s3_q      <= 1'b0;
               q_o[g]    <= 1'b0;
            end
            else
            begin
               s1_q <= d_i[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q)
               begin
                  q_o[g] <= s3_q;
               end
            end
         end
      end
   endgenerate
endmodule

// File: fsh_ctrl_props.sv
// Purpose: Checks the strobe and APB timing at the ports of the flash host.
// Assumes: Counts of 5 setup, 18 write strobe and 21 read strobe cycles.
// Notes:   Attached by the bind after the module.
module fsh_ctrl_props (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [19:0] fl_addr_o,
   input wire logic [15:0] fl_dq_o,
   input wire logic        fl_dq_oe_o,
   input wire logic        fl_ce_n_o,
   input wire logic        fl_we_n_o,
   input wire logic        fl_oe_n_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   write_pulse_a: assert property ($fell(fl_we_n_o) |-> ##18 $rose(fl_we_n_o))
      else $error("write strobe width wrong");
   read_pulse_a: assert property ($fell(fl_oe_n_o) |-> ##21 $rose(fl_oe_n_o))
      else $error("read strobe width wrong");
   setup_len_a: assert property ($fell(fl_ce_n_o) |->
      (fl_we_n_o && fl_oe_n_o) [*5] ##1 (!fl_we_n_o || !fl_oe_n_o))
      else $error("setup time wrong");
   no_fight_a: assert property (!fl_oe_n_o |-> !fl_dq_oe_o && fl_we_n_o)
      else $error("data bus contention");
   write_drive_a: assert property (!fl_we_n_o |-> fl_dq_oe_o && !fl_ce_n_o)
      else $error("write strobe without data");
   write_hold_a: assert property ($rose(fl_we_n_o) |->
      ($stable(fl_addr_o) && $stable(fl_dq_o)) [*7])
      else $error("hold after write broken");
   addr_steady_a: assert property (!fl_ce_n_o && !$fell(fl_ce_n_o) |-> $stable(fl_addr_o))
      else $error("address moved in cycle");
   unmapped_err_a: assert property (psel && penable && paddr > 12'h01C |->
      pslverr && prdata == 32'h0 && pready)
      else $error("unmapped access not refused");
   idle_bus_a: assert property (!(psel && penable) |-> prdata == 32'h0 && !pslverr)
      else $error("bus outputs outside access");
endmodule
bind fsh_ctrl fsh_ctrl_props chk_u (.clk_i(clk_i), .rst_i(rst_i), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o),
   .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o));

// File: fsh_flash_model.sv
// Purpose: Behavioural parallel flash for the host bench.
// Assumes: Word mode, sector PSEC protected.
//          Modes: 0 read, 1 id, 2 program, 3 time-out, 4 erase, 5 suspend.
// Notes:   Maker and device codes are arbitrary values.
module fsh_flash_model #(
   parameter logic [19:0] UA1      = 20'h00555,
   parameter logic [19:0] UA2      = 20'h002AA,
   parameter logic [15:0] MAKER    = 16'h003C,
   parameter logic [15:0] DEVID    = 16'h1234,
   parameter int          PROG_NS  = 2000,
   parameter int          TO_NS    = 50000,
   parameter int          ERASE_NS = 20000,
   parameter int          PERA_NS  = 100000,
   parameter logic [3:0]  PSEC     = 4'h7
) (
   input  wire logic [19:0] addr_i,
   input  wire logic [15:0] dq_i,
   input  wire logic        ce_n_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i,
   output logic      [15:0] dq_o,
   output logic             rb_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0]  mode = 3'd0;
   logic [2:0]  back = 3'd0;
   logic [1:0]  step = 2'd0;
   logic        pgm  = 1'b0;
   logic        ers  = 1'b0;
   logic        tog  = 1'b0;
   logic        t2   = 1'b0;
   logic        pv   = 1'b0;
   logic        armed = 1'b0;
   logic [3:0]  esec = 4'h0;
   logic [15:0] rd   = 16'h0000;
   logic [15:0] mem [0:255];
   realtime     t_end;
   initial
   begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Chip enable and write strobe rise together, so the write is armed at the falling strobe.
   always @(negedge we_n_i)
   begin
      armed = !ce_n_i && oe_n_i;
   end
   always @(posedge we_n_i)
   begin
      if (armed && mode != 3'd2)
      begin
         if (mode == 3'd4)
            mode = (dq_i[7:0] == 8'hB0) ? 3'd5 : mode;
         else if (mode == 3'd5 && dq_i[7:0] == 8'h30)
         begin
            mode = 3'd4;
            t_end = $realtime + ERASE_NS;
         end
         else if (mode == 3'd3 && dq_i[7:0] == 8'hB0)
            mode = 3'd5;
         else if (step == 2'd0 && addr_i == UA1 && dq_i[7:0] == 8'hAA)
            step = 2'd1;
         else if (step == 2'd1 && addr_i == UA2 && dq_i[7:0] == 8'h55)
            step = 2'd2;
         else if (step == 2'd2)
         begin
            step = 2'd0;
            if (dq_i[7:0] == 8'h90 && (mode == 3'd0 || mode == 3'd5))
            begin
               back = mode;
               mode = 3'd1;
            end
            pgm = pgm | (dq_i[7:0] == 8'hA0);
            ers = ers | (dq_i[7:0] == 8'h80);
            if (dq_i[7:0] == 8'h30 && (ers || mode == 3'd3))
            begin
               ers = 1'b0;
               esec = addr_i[19:16];
               mode = 3'd3;
               t_end = $realtime + TO_NS;
            end
         end
         else if (pgm)
         begin
            pgm = 1'b0;
            if (addr_i[19:16] != PSEC)
               mem[addr_i[7:0]] = mem[addr_i[7:0]] & dq_i;
            pv = dq_i[7];
            back = mode;
            mode = 3'd2;
            t_end = $realtime + PROG_NS;
         end
         else if (mode == 3'd3)
            mode = 3'd0;
         else if (dq_i[7:0] == 8'hF0 && mode == 3'd1)
            mode = back;
      end
      armed = 1'b0;
   end
   always #20
   begin
      if ((mode == 3'd2 || mode == 3'd3 || mode == 3'd4) && $realtime >= t_end)
      begin
         if (mode == 3'd3)
            t_end = $realtime + ((esec == PSEC) ? PERA_NS : ERASE_NS);
         mode = (mode == 3'd3) ? 3'd4 : (mode == 3'd2) ? back : 3'd0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   always @(negedge oe_n_i)
   begin
      if (ce_n_i)
         rd = ~rd;
      else if (mode == 3'd1)
         rd = (addr_i[7:0] == 8'h00) ? MAKER : (addr_i[7:0] == 8'h01) ? DEVID :
              {15'h0000, addr_i[7:0] == 8'h02 && addr_i[19:16] == PSEC};
      else if (mode == 3'd2 || mode == 3'd3 || mode == 3'd4)
      begin
         rd = {8'h00, (mode == 3'd2) ? ~pv : 1'b0, tog, 2'b00, mode == 3'd4, 3'b000};
         tog = ~tog;
      end
      else if (mode == 3'd5 && addr_i[19:16] == esec)
      begin
         rd = {8'h00, 1'b1, tog, 3'b000, t2, 2'b00};
         t2 = ~t2;
      end
      else
         rd = mem[addr_i[7:0]];
   end
   assign dq_o   = (!ce_n_i && !oe_n_i) ? rd : ~rd;
   assign rb_n_o = !(mode == 3'd2 || mode == 3'd3 || mode == 3'd4);
endmodule

// File: tb_fsh_ctrl.sv
// Purpose: Drives the flash host over APB against the flash model.
// Assumes: Zero wait APB, small erase wait count.
// Notes:   Expected values come from the map header and model parameters.
`include "fsh_map.svh"
module tb_fsh_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_i, psel, penable, pwrite, pready, pslverr, e, dq_oe, ce_n, we_n;
   logic        oe_n, rb_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, x;
   logic [19:0] fl_addr;
   logic [15:0] dq_h, dq_f;
   int          num_errors, samples_checked, cyc;
   // Maker and device codes are arbitrary values.
   localparam logic [19:0] UA1   = 20'h00555;
   localparam logic [19:0] UA2   = 20'h002AA;
   localparam logic [15:0] MAKER = 16'h003C;
   localparam logic [15:0] DEVID = 16'h1234;
   fsh_ctrl #(.ERASE_WAIT_CYC(20)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fl_addr_o(fl_addr), .fl_dq_o(dq_h),
      .fl_dq_oe_o(dq_oe), .fl_dq_i(dq_f), .fl_ce_n_o(ce_n), .fl_we_n_o(we_n),
      .fl_oe_n_o(oe_n), .ready_busy_n_out_i(rb_n));
   fsh_flash_model #(.UA1(UA1), .UA2(UA2), .MAKER(MAKER), .DEVID(DEVID)) flash_u (
      .addr_i(fl_addr), .dq_i(dq_h), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .dq_o(dq_f),
      .rb_n_o(rb_n));
   ////////////////////////////////////////////////////////////////////////////
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) @(posedge clk_i);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] xp);
      samples_checked++;
      if (s !== xp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, xp, s);
      end
   endtask
   task op(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d);
      apb(1'b1, `FSH_OFS_ADDR, {12'h000, a});
      apb(1'b1, `FSH_OFS_WDATA, {16'h0000, d});
      apb(1'b1, `FSH_OFS_CTRL, {28'h0000000, c});
      apb(1'b0, `FSH_OFS_STATUS, 32'h0);
      while (q[`FSH_ST_BUSY] !== 1'b0) apb(1'b0, `FSH_OFS_STATUS, 32'h0);
   endtask
   task rdf(input logic [19:0] a);
      op(4'h2, a, 16'h0000);
      apb(1'b0, `FSH_OFS_RDATA, 32'h0);
   endtask
   task stop_test;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         num_errors++;
         stop_test;
      end
   end
   initial
   begin
      {rst_i, psel, penable, pwrite, paddr, pwdata, num_errors, samples_checked, cyc} = '0;
      rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      apb(1'b0, `FSH_OFS_UNLK_A1, 32'h0);
      chk("unlock a1 reset", q, {12'h000, `FSH_RST_UNLK_A1});
      apb(1'b0, `FSH_OFS_CODES, 32'h0);
      chk("codes reset", q, {16'h0000, `FSH_RST_CODES});
      apb(1'b0, `FSH_OFS_STATUS, 32'h0);
      chk("status idle", q, 32'h00000002);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped", {q[30:0], e}, 32'h00000001);
      apb(1'b1, `FSH_OFS_UNLK_A1, {12'h000, UA1});
      apb(1'b1, `FSH_OFS_UNLK_A2, {12'h000, UA2});
      apb(1'b1, `FSH_OFS_CODES, 32'h0000AA55);
      apb(1'b0, `FSH_OFS_UNLK_A2, 32'h0);
      chk("unlock a2", q, {12'h000, UA2});
      op(4'h3, 20'h00000, 16'h0090);
      rdf(20'h00000);
      chk("maker code", q, {16'h0000, MAKER});
      rdf(20'h50001);
      chk("device code", q, {16'h0000, DEVID});
      rdf(20'h30002);
      chk("protect query", q, 32'h00000000);
      rdf(20'h70002);
      chk("protect set", q, 32'h00000001);
      rdf(20'hF0000);
      chk("maker again", q, {16'h0000, MAKER});
      op(4'h1, 20'h00000, 16'h00F0);
      rdf(20'h00000);
      chk("array after id", q, 32'h0000FFFF);
      op(4'h3, 20'h00000, 16'h00A0);
      op(4'h1, 20'h00005, 16'h1234);
      op(4'h1, 20'h00000, 16'h00F0);
      rdf(20'h00005);
      chk("program poll", {q[31:8], q[7]}, 32'h00000001);
      apb(1'b0, `FSH_OFS_STATUS, 32'h0);
      chk("pin busy", q[1], 32'h0);
      op(4'h4, 20'h00005, 16'h0000);
      apb(1'b0, `FSH_OFS_STATUS, 32'h0);
      chk("program status", q, 32'h00000002);
      apb(1'b0, `FSH_OFS_RDATA, 32'h0);
      chk("program data", q, 32'h00001234);
      op(4'h3, 20'h00000, 16'h00A0);
      op(4'h1, 20'h70005, 16'h0000);
      op(4'h4, 20'h70005, 16'h0000);
      apb(1'b0, `FSH_OFS_RDATA, 32'h0);
      chk("protected program", q, 32'h00001234);
      op(4'h3, 20'h00000, 16'h0080);
      op(4'h3, 20'h30000, 16'h0030);
      op(4'h1, 20'h00000, 16'h00B0);
      apb(1'b0, `FSH_OFS_STATUS, 32'h0);
      chk("suspend ready", q, 32'h00000002);
      rdf(20'h30000);
      x = q;
      rdf(20'h30010);
      chk("suspended read", {q[7:5], q[2]}, {1'b1, x[6], 1'b0, ~x[2]});
      rdf(20'h00005);
      chk("other sector", q, 32'h00001234);
      op(4'h1, 20'h00000, 16'h0030);
      op(4'h1, 20'h00000, 16'h0030);
      apb(1'b0, `FSH_OFS_STATUS, 32'h0);
      chk("resumed busy", q[1], 32'h0);
      op(4'hC, 20'h30000, 16'h0000);
      apb(1'b0, `FSH_OFS_STATUS, 32'h0);
      chk("erase done", q, 32'h0000000A);
      stop_test;
   end
endmodule
